// ===== charge_integration_sequencer_bench.sv
// Purpose: self-checking bench of the sequencer
// Assumes: M=4, K=8, initial level 100
// Notes: a warm cycle follows each mode change
`timescale 1ns/1ns
`include "cis_map.svh"
module charge_integration_sequencer_bench;
  import cis_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, rd;
  wire logic [31:0] prdata, result;
  wire logic pready, pslverr, cap_reset, rate_clear, sampling, result_valid, fss_n;
  wire logic signed [19:0] trk;
  int n_errors = 0;
  int n_tests = 0;
  int n_clr = 0;
  int c0 = 0;
  // Oversample count of the cycle being ended; the first cycle after reset still uses 16
  int m_now = 16;
  // Last entry: straight binary, result below the unipolar floor
  logic [31:0] ctl_t [5] = '{32'hb, 32'h9, 32'h9, 32'hf, 32'h3};
  logic signed [19:0] fin_t [5] = '{20'sh00096, 20'sh0012c, 20'sh493e0, 20'sh30da4, 20'shff830};
  logic [31:0] exp_t [5] = '{32'hc8, 32'h4b0, 32'hffffc, 32'h7fffe, 32'h7ffff001};
  cis_seq uut(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .final_sample_start_n(fss_n), .track_data(trk), .cap_reset(cap_reset), .rate_clear(rate_clear),
    .sampling(sampling), .result_valid(result_valid), .result(result));
  cis_ctrl_model ctl(.pclk(pclk), .final_sample_start_n(fss_n), .track_data(trk));
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk)
    if (rate_clear === 1'b1) n_clr <= n_clr + 1;
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for ready
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_track();
    int w;
    w = 0;
    do
    begin
      apb(1'b0, `CIS_OFF_STAT, 32'h0, rd);
      w++;
    end
    while (rd[2:0] !== CIS_TRACK && w < 80);
    check("track state", 32'(CIS_TRACK), {29'h0, rd[2:0]});
  endtask
  task automatic wait_res();
    int w;
    w = 0;
    do
    begin
      @(posedge pclk);
      w++;
    end
    while (result_valid !== 1'b1 && w < 300);
    check("result_valid", 32'h1, {31'h0, result_valid});
    // M final samples plus the strobe synchroniser delay
    check("final span", 32'h1, {31'h0, (w > m_now && w <= m_now + 3)});
  endtask
  task automatic run_cycle(input logic signed [19:0] b, input logic chk, input logic [31:0] e);
    wait_track();
    ctl.level(b);
    ctl.strobe(2);
    wait_res();
    ctl.level(20'sh00064);
    if (chk)
    begin
      check("result pin", e, result);
      apb(1'b0, `CIS_OFF_RES, 32'h0, rd);
      check("result reg", e, rd);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    #500000;
    n_errors++;
    complete_run();
  end
  // ********************
  // Tests
  // ********************
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `CIS_OFF_OVS, 32'h0, rd);
    check("ovs reset", 32'h10, rd);
    apb(1'b0, 8'h20, 32'h0, rd);
    check("unmapped", 32'h1, {rd[30:0], err});
    apb(1'b1, `CIS_OFF_OVS, 32'h4, rd);
    apb(1'b1, `CIS_OFF_ACQ, 32'h8, rd);
    apb(1'b1, `CIS_OFF_CTRL, 32'h7, rd);
    apb(1'b0, `CIS_OFF_STAT, 32'h0, rd);
    check("cfg error", 32'h1, {31'h0, rd[4]});
    $display("test registers done");
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b1, `CIS_OFF_CTRL, ctl_t[i], rd);
      run_cycle(20'sh00064, 1'b0, 32'h0);
      if (i == 0)
      begin
        c0 = n_clr;
        m_now = 4;
      end
      run_cycle(fin_t[i], 1'b1, exp_t[i]);
    end
    check("rate kept", 32'(c0), 32'(n_clr));
    $display("test results done");
    for (int i = 0; i < 2; i++)
    begin
      apb(1'b1, `CIS_OFF_CTRL, 32'hb - 32'(i), rd);
      run_cycle(20'sh00064, 1'b0, 32'h0);
      wait_track();
      ctl.hold(1'b0);
      repeat (20) @(posedge pclk);
      check("held clear", 32'h3, {30'h0, rate_clear, cap_reset});
      apb(1'b0, `CIS_OFF_STAT, 32'h0, rd);
      check("held state", 32'(CIS_HOLD), {29'h0, rd[2:0]});
      ctl.hold(1'b1);
      run_cycle(20'sh00096, 1'b1, 32'hc8);
      if (i == 1)
      begin
        wait_track();
        ctl.strobe(2);
        wait_res();
        check("end discharge", 32'h1, {30'h0, rate_clear, cap_reset});
      end
    end
    $display("test long strobe done");
    presetn <= 1'b0;
    @(posedge pclk);
    check("reset outputs", 32'h1, {result[30:0], cap_reset});
    presetn <= 1'b1;
    apb(1'b0, `CIS_OFF_CTRL, 32'h0, rd);
    check("ctrl reset", 32'h0, rd);
    $display("test second reset done");
    complete_run();
  end
endmodule

// ===== cis_ctrl_model.sv
// Purpose: outside controller: strobe and tracking samples
// Assumes: strobe active low, idle high
// Notes: changes only just after a rising edge
`timescale 1ns/1ns
module cis_ctrl_model
(
  input wire logic pclk,
  output logic final_sample_start_n,
  output logic signed [19:0] track_data
);
  initial
  begin
    final_sample_start_n = 1'b1;
    track_data = 20'sh00064;
  end
  task automatic hold(input logic v);
    @(posedge pclk);
    final_sample_start_n <= v;
  endtask
  // Short pulse, fewer than M clocks, keeps continuous running
  task automatic strobe(input int len);
    hold(1'b0);
    repeat (len) @(posedge pclk);
    final_sample_start_n <= 1'b1;
  endtask
  task automatic level(input logic signed [19:0] v);
    @(posedge pclk);
    track_data <= v;
  endtask
endmodule

// ===== cis_map.svh
// Purpose: register offsets, fields and reset values of the sequencer
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: definitions only
`ifndef CIS_MAP_SVH
`define CIS_MAP_SVH

// ********************
// Offsets
// ********************
`define CIS_OFF_CTRL 8'h00
`define CIS_OFF_OVS 8'h04
`define CIS_OFF_ACQ 8'h08
`define CIS_OFF_STAT 8'h0c
`define CIS_OFF_RES 8'h10
`define CIS_OFF_INIT 8'h14
`define CIS_OFF_FIN 8'h18
`define CIS_OFF_LEN 8'h1c

// ********************
// Fields
// ********************
`define CIS_CTRL_CONT 0
`define CIS_CTRL_OCS 1
`define CIS_CTRL_BIP 2
`define CIS_CTRL_TWOS 3
`define CIS_STAT_NEW 3
`define CIS_STAT_CFG 4

// ********************
// Reset values
// ********************
`define CIS_CTRL_RST 4'h0
`define CIS_OVS_RST 9'h010
`define CIS_ACQ_RST 8'h10

`endif

// ===== cis_pkg.sv
// Purpose: types shared by the sequencer
// Assumes: nothing
// Notes: phase encoding shows in the status register
package cis_pkg;
  typedef enum logic [2:0] {
    CIS_HOLD,
    CIS_RST,
    CIS_ACQ,
    CIS_INIT,
    CIS_TRACK,
    CIS_FINAL
  } cis_state_t;
endpackage

// ===== cis_seq.sv
// Purpose: integration cycle sequencer with APB registers
// Assumes: track_data comes from logic on pclk
// Notes: one wait state on every APB access
`timescale 1ns/1ns
`include "cis_map.svh"

module cis_seq
  import cis_pkg::*;
#(
  parameter int DATA_W = 20,
  parameter int ACC_W = 30,
  parameter int FS_CODE = 262143
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic final_sample_start_n,
  input wire logic signed [DATA_W-1:0] track_data,
  output logic cap_reset,
  output logic rate_clear,
  output logic sampling,
  output logic result_valid,
  output logic [31:0] result
);

  // ********************
  // Strobe synchroniser
  // ********************
  logic strb_s1_r;
  logic strb_s2_r;
  logic strb_s3_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      strb_s1_r <= 1'b1;
      strb_s2_r <= 1'b1;
      strb_s3_r <= 1'b1;
    end
    else
    begin
      strb_s1_r <= final_sample_start_n;
      strb_s2_r <= strb_s1_r;
      strb_s3_r <= strb_s2_r;
    end
  end

  // Low level is active; the edge marks the start
  wire strb_act = ~strb_s2_r;
  wire strb_fall = strb_s3_r & ~strb_s2_r;

  // ********************
  // APB decode
  // ********************
  logic [3:0] ctrl_r;
  logic [8:0] ovs_r;
  logic [7:0] acq_r;
  logic new_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;

  wire acc_ph = psel & penable & ~pready_r;
  wire done_ph = psel & penable & pready_r;
  wire hit_ctrl = paddr == `CIS_OFF_CTRL;
  wire hit_ovs = paddr == `CIS_OFF_OVS;
  wire hit_acq = paddr == `CIS_OFF_ACQ;
  wire hit_stat = paddr == `CIS_OFF_STAT;
  wire hit_res = paddr == `CIS_OFF_RES;
  wire hit_init = paddr == `CIS_OFF_INIT;
  wire hit_fin = paddr == `CIS_OFF_FIN;
  wire hit_len = paddr == `CIS_OFF_LEN;
  wire hit_any = hit_ctrl | hit_ovs | hit_acq | hit_stat | hit_res | hit_init | hit_fin | hit_len;
  wire wr_ok = done_ph & pwrite & hit_any;
  wire rd_res = done_ph & ~pwrite & hit_res;

  wire mode_cont = ctrl_r[`CIS_CTRL_CONT];
  wire bipolar = ctrl_r[`CIS_CTRL_BIP];
  wire twos = ctrl_r[`CIS_CTRL_TWOS];
  // Straight binary cannot carry a signed bipolar difference
  wire cfg_err = ctrl_r[`CIS_CTRL_OCS] & bipolar & ~twos;
  wire ocs_on = ctrl_r[`CIS_CTRL_OCS] & ~cfg_err;

  // ********************
  // Sequencer state
  // ********************
  cis_state_t state_r;
  cis_state_t state_nxt;
  logic [8:0] cnt_r;
  logic [8:0] cnt_nxt;
  logic [8:0] m_lat_r;
  logic [7:0] k_lat_r;
  logic [31:0] ncnt_r;
  logic [31:0] len_r;
  logic signed [ACC_W-1:0] init_acc_r;
  logic signed [ACC_W-1:0] fin_acc_r;
  logic signed [ACC_W-1:0] init_pt_r;
  logic signed [ACC_W-1:0] fin_pt_r;
  logic [31:0] res_r;
  logic cap_reset_r;
  logic rate_clear_r;
  logic sampling_r;
  logic result_valid_r;

  // Zero counts would stretch a phase to a full counter wrap
  wire [8:0] m_req = (ovs_r == 9'h000) ? 9'h001 : ovs_r;
  wire [7:0] k_req = (acq_r == 8'h00) ? 8'h01 : acq_r;

  wire signed [ACC_W-1:0] smp = ACC_W'(track_data);
  wire cnt_m_end = cnt_r == (m_lat_r - 9'h001);
  wire cnt_k_end = cnt_r == {1'b0, k_lat_r - 8'h01};
  wire fin_end = (state_r == CIS_FINAL) & cnt_m_end;
  wire go_hold = fin_end & (strb_act | ~mode_cont);

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r + 9'h001;
    unique case (state_r)
      CIS_HOLD:
      begin
        cnt_nxt = 9'h000;
        // New integration only once the strobe is released
        if (!strb_act)
          state_nxt = CIS_RST;
      end
      CIS_RST:
      begin
        cnt_nxt = 9'h001;
        if (k_req == 8'h01)
        begin
          state_nxt = CIS_INIT;
          cnt_nxt = 9'h000;
        end
        else
          state_nxt = CIS_ACQ;
      end
      CIS_ACQ:
      begin
        if (cnt_k_end)
        begin
          state_nxt = CIS_INIT;
          cnt_nxt = 9'h000;
        end
      end
      CIS_INIT:
      begin
        if (cnt_m_end)
        begin
          state_nxt = CIS_TRACK;
          cnt_nxt = 9'h000;
        end
      end
      CIS_TRACK:
      begin
        cnt_nxt = 9'h000;
        if (strb_fall)
          state_nxt = CIS_FINAL;
      end
      CIS_FINAL:
      begin
        if (cnt_m_end)
        begin
          cnt_nxt = 9'h000;
          if (go_hold)
            state_nxt = CIS_HOLD;
          else
            state_nxt = CIS_RST;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= CIS_HOLD;
      cnt_r <= 9'h000;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // M and K are frozen for the whole cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      m_lat_r <= 9'h001;
      k_lat_r <= 8'h01;
    end
    else if (state_r == CIS_RST)
    begin
      m_lat_r <= m_req;
      k_lat_r <= k_req;
    end
  end

  // Cycle length N as set by the strobe timing
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ncnt_r <= 32'h0;
      len_r <= 32'h0;
    end
    else if (state_r == CIS_RST)
      ncnt_r <= 32'h1;
    else if (state_r != CIS_HOLD)
    begin
      ncnt_r <= ncnt_r + 32'h1;
      if (fin_end)
        len_r <= ncnt_r + 32'h1;
    end
  end

  // ********************
  // Data points
  // ********************
  wire signed [ACC_W-1:0] fin_sum = fin_acc_r + smp;
  wire signed [ACC_W-1:0] diff = ocs_on ? fin_sum - init_acc_r : fin_sum;
  wire signed [ACC_W-1:0] hi_uni = ACC_W'(FS_CODE) * ACC_W'(m_lat_r);
  wire signed [ACC_W-1:0] hi_lim = bipolar ? (hi_uni >>> 1) : hi_uni;
  wire signed [ACC_W-1:0] lo_uni = -(hi_uni >>> 8);
  wire signed [ACC_W-1:0] lo_bip = -(hi_lim + (hi_lim >>> 7));
  wire signed [ACC_W-1:0] lo_lim = bipolar ? lo_bip : lo_uni;
  wire signed [ACC_W-1:0] clip = (diff > hi_lim) ? hi_lim : (diff < lo_lim) ? lo_lim : diff;
  wire [31:0] clip_w = 32'(clip);
  // Straight binary is offset binary: flip the sign bit
  wire [31:0] res_fmt = twos ? clip_w : {~clip_w[31], clip_w[30:0]};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      init_acc_r <= '0;
      fin_acc_r <= '0;
    end
    else
    begin
      if (state_r == CIS_RST)
        init_acc_r <= '0;
      else if (state_r == CIS_INIT)
        init_acc_r <= init_acc_r + smp;
      if (state_r == CIS_TRACK)
        fin_acc_r <= '0;
      else if (state_r == CIS_FINAL)
        fin_acc_r <= fin_sum;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      init_pt_r <= '0;
      fin_pt_r <= '0;
      res_r <= 32'h0;
      result_valid_r <= 1'b0;
    end
    else
    begin
      result_valid_r <= fin_end;
      if (fin_end)
      begin
        init_pt_r <= init_acc_r;
        fin_pt_r <= fin_sum;
        res_r <= res_fmt;
      end
    end
  end

  // ********************
  // Analog controls
  // ********************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cap_reset_r <= 1'b1;
      rate_clear_r <= 1'b1;
      sampling_r <= 1'b0;
    end
    else
    begin
      // Discharge in the first acquisition period and while held
      cap_reset_r <= (state_nxt == CIS_RST) | (state_nxt == CIS_HOLD);
      // Rate survives a normal continuous turnaround
      rate_clear_r <= (fin_end & strb_act) | ((state_r == CIS_HOLD) & strb_act);
      sampling_r <= (state_nxt == CIS_INIT) | (state_nxt == CIS_FINAL);
    end
  end

  // ********************
  // Registers
  // ********************
  wire [31:0] stat_w = {27'h0, cfg_err, new_r, state_r};
  wire [31:0] rd_mux = hit_ctrl ? {28'h0, ctrl_r} :
                       hit_ovs ? {23'h0, ovs_r} :
                       hit_acq ? {24'h0, acq_r} :
                       hit_stat ? stat_w :
                       hit_res ? res_r :
                       hit_init ? 32'(init_pt_r) :
                       hit_fin ? 32'(fin_pt_r) :
                       hit_len ? len_r : 32'h0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r <= `CIS_CTRL_RST;
      ovs_r <= `CIS_OVS_RST;
      acq_r <= `CIS_ACQ_RST;
    end
    else if (wr_ok)
    begin
      if (hit_ctrl)
        ctrl_r <= pwdata[3:0];
      if (hit_ovs)
        ovs_r <= pwdata[8:0];
      if (hit_acq)
        acq_r <= pwdata[7:0];
    end
  end

  // New result flag: a fresh result beats the read that clears it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      new_r <= 1'b0;
    else if (fin_end)
      new_r <= 1'b1;
    else if (rd_res)
      new_r <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
    end
    else
    begin
      pready_r <= acc_ph;
      pslverr_r <= acc_ph & ~hit_any;
      if (acc_ph & ~pwrite)
        prdata_r <= rd_mux;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign cap_reset = cap_reset_r;
  assign rate_clear = rate_clear_r;
  assign sampling = sampling_r;
  assign result_valid = result_valid_r;
  assign result = res_r;

endmodule

// ===== cis_seq_checker.sv
// Purpose: port-level checks of the sequencer
// Assumes: one clock, reset active low
// Notes: bound to every cis_seq instance
`timescale 1ns/1ns
module cis_seq_checker
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic final_sample_start_n,
  input wire logic cap_reset,
  input wire logic rate_clear,
  input wire logic sampling,
  input wire logic result_valid,
  input wire logic [31:0] result
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_ready_wait:
    assert property ($rose(penable) && psel |-> !pready ##1 pready) else $error("late ready");
  chk_ready_pulse:
    assert property (pready |=> !pready) else $error("ready too long");
  chk_err_ready:
    assert property (pslverr |-> pready && (pwrite || prdata == 32'h0)) else $error("bad error reply");
  chk_reset_excl:
    assert property (!(cap_reset && sampling)) else $error("sampling in reset");
  chk_clear_in_reset:
    assert property (rate_clear |-> cap_reset) else $error("clear outside reset");
  chk_hold_held:
    assert property (rate_clear && !final_sample_start_n |=> cap_reset && rate_clear) else $error("left hold");
  chk_clear_cause:
    assert property ($rose(rate_clear) |-> !$past(final_sample_start_n, 2) || !$past(final_sample_start_n, 3)
      || !$past(final_sample_start_n, 4)) else $error("clear without strobe");
  chk_valid_pulse:
    assert property (result_valid |=> !result_valid) else $error("valid too long");
  chk_valid_cause:
    assert property ($rose(result_valid) |-> $past(sampling) || $past(sampling, 2)) else $error("valid w/o final");
  chk_result_hold:
    assert property (!result_valid |-> $stable(result)) else $error("result moved");
  cov_result: cover property (result_valid);
  cov_clear: cover property ($rose(rate_clear));
  cov_err: cover property (pslverr);
endmodule

bind cis_seq cis_seq_checker chk(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .final_sample_start_n(final_sample_start_n), .cap_reset(cap_reset), .rate_clear(rate_clear),
  .sampling(sampling), .result_valid(result_valid), .result(result));
